/* pkg/bbfe_pkg.sv */
// Purpose: constants and types for the branch, bit and flag execution unit
// Assumes: one core clock, flags held inside the unit
// Notes:   opcodes are an internal encoding chosen by the decoder in front
package bbfe_pkg;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned OFS_W  = 7;
  localparam int unsigned RIDX_W = 5;
  localparam int unsigned IOA_W  = 5;
  localparam int unsigned SEL_W  = 3;
  // flag positions in the status word
  localparam logic [SEL_W-1:0] FLAG_C = 3'h0;
  localparam logic [SEL_W-1:0] FLAG_Z = 3'h1;
  localparam logic [SEL_W-1:0] FLAG_N = 3'h2;
  localparam logic [SEL_W-1:0] FLAG_V = 3'h3;
  localparam logic [SEL_W-1:0] FLAG_S = 3'h4;
  localparam logic [SEL_W-1:0] FLAG_H = 3'h5;
  localparam logic [SEL_W-1:0] FLAG_T = 3'h6;
  localparam logic [SEL_W-1:0] FLAG_I = 3'h7;
  localparam logic [DATA_W-1:0] FLAGS_RESET = 8'h00;
  localparam logic [DATA_W-1:0] DATA_ZERO   = 8'h00;
  localparam int unsigned MSB = DATA_W - 1;

  typedef enum logic [4:0] {
    branch_on_indexed_flag_high = 5'h00,
    branch_on_indexed_flag_low  = 5'h01,
    branch_on_zero_high         = 5'h02,
    branch_on_zero_low          = 5'h03,
    branch_on_carry_high        = 5'h04,
    branch_on_carry_low         = 5'h05,
    branch_unsigned_not_below   = 5'h06,
    branch_unsigned_below       = 5'h07,
    branch_on_negative          = 5'h08,
    branch_on_nonnegative       = 5'h09,
    branch_signed_not_less      = 5'h0A,
    branch_signed_less          = 5'h0B,
    branch_on_half_carry_high   = 5'h0C,
    branch_on_half_carry_low    = 5'h0D,
    branch_on_transfer_high     = 5'h0E,
    branch_on_transfer_low      = 5'h0F,
    branch_on_overflow_low      = 5'h10,
    branch_when_irq_on          = 5'h11,
    branch_when_irq_off         = 5'h12,
    io_bit_force_one            = 5'h13,
    io_bit_force_zero           = 5'h14,
    shift_left_logical          = 5'h15,
    shift_right_logical         = 5'h16,
    rotate_left_via_carry       = 5'h17,
    rotate_right_via_carry      = 5'h18,
    arith_shift_right           = 5'h19,
    copy_bit_to_transfer_flag   = 5'h1A,
    load_bit_from_transfer_flag = 5'h1B,
    flag_force_one              = 5'h1C,
    flag_force_zero             = 5'h1D,
    register_copy               = 5'h1E,
    op_none                     = 5'h1F
  } bbfe_op_type;

  typedef enum logic [1:0] {
    st_idle     = 2'b00,
    st_branch   = 2'b01,
    st_io_write = 2'b10
  } bbfe_state_type;
endpackage

/* logic/bbfe_exec.sv */
// Purpose: execute branch, bit and flag instructions of an 8-bit core
// Assumes: register file and io space answer reads combinationally
// Notes:   one instruction at a time, accepted when instr_ready is high
`timescale 1ns/1ps
`default_nettype none
module bbfe_exec #(
  parameter int unsigned PC_W = 16
) (
  input  wire logic                         ref_clk,
  input  wire logic                         rst,
  input  wire logic                         instr_valid,
  input  wire bbfe_pkg::bbfe_op_type        instr_op,
  input  wire logic [bbfe_pkg::SEL_W-1:0]   instr_sel,
  input  wire logic [bbfe_pkg::OFS_W-1:0]   instr_offset,
  input  wire logic [bbfe_pkg::RIDX_W-1:0]  instr_rd_idx,
  input  wire logic [bbfe_pkg::IOA_W-1:0]   instr_io_addr,
  input  wire logic [PC_W-1:0]              pc_in,
  input  wire logic [bbfe_pkg::DATA_W-1:0]  rd_data,
  input  wire logic [bbfe_pkg::DATA_W-1:0]  rr_data,
  input  wire logic [bbfe_pkg::DATA_W-1:0]  io_rd_data,
  output logic                              instr_ready,
  output logic                              done,
  output logic                              pc_load,
  output logic [PC_W-1:0]                   pc_target,
  output logic                              reg_we,
  output logic [bbfe_pkg::RIDX_W-1:0]       reg_waddr,
  output logic [bbfe_pkg::DATA_W-1:0]       reg_wdata,
  output logic                              io_re,
  output logic                              io_we,
  output logic [bbfe_pkg::IOA_W-1:0]        io_addr,
  output logic [bbfe_pkg::DATA_W-1:0]       io_wdata,
  output logic [bbfe_pkg::DATA_W-1:0]       status_flags_word
);
  import bbfe_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  bbfe_state_type      state_r,     state_nxt;
  logic                ready_r,     ready_nxt;
  logic                done_r,      done_nxt;
  logic                pc_load_r,   pc_load_nxt;
  logic [PC_W-1:0]     pc_target_r, pc_target_nxt;
  logic                reg_we_r,    reg_we_nxt;
  logic [RIDX_W-1:0]   reg_waddr_r, reg_waddr_nxt;
  logic [DATA_W-1:0]   reg_wdata_r, reg_wdata_nxt;
  logic                io_re_r,     io_re_nxt;
  logic                io_we_r,     io_we_nxt;
  logic [IOA_W-1:0]    io_addr_r,   io_addr_nxt;
  logic [DATA_W-1:0]   io_wdata_r,  io_wdata_nxt;
  logic [DATA_W-1:0]   flags_r,     flags_nxt;
  logic                io_val_r,    io_val_nxt;
  logic [SEL_W-1:0]    io_bit_r,    io_bit_nxt;

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  logic              accept;
  logic              is_branch;
  logic              taken;
  logic [PC_W-1:0]   ofs_ext;
  logic [DATA_W-1:0] sh_res;
  logic              sh_c;
  logic              is_shift;

  always_comb begin
    accept    = instr_valid && ready_r && (state_r == st_idle);
    is_branch = 1'b1;
    taken     = 1'b0;
    unique case (instr_op)
      branch_on_indexed_flag_high: taken = flags_r[instr_sel];
      branch_on_indexed_flag_low:  taken = !flags_r[instr_sel];
      branch_on_zero_high:         taken = flags_r[FLAG_Z];
      branch_on_zero_low:          taken = !flags_r[FLAG_Z];
      branch_on_carry_high,
      branch_unsigned_below:       taken = flags_r[FLAG_C];
      branch_on_carry_low,
      branch_unsigned_not_below:   taken = !flags_r[FLAG_C];
      branch_on_negative:          taken = flags_r[FLAG_N];
      branch_on_nonnegative:       taken = !flags_r[FLAG_N];
      branch_signed_not_less:      taken = !(flags_r[FLAG_N] ^ flags_r[FLAG_V]);
      branch_signed_less:          taken = flags_r[FLAG_N] ^ flags_r[FLAG_V];
      branch_on_half_carry_high:   taken = flags_r[FLAG_H];
      branch_on_half_carry_low:    taken = !flags_r[FLAG_H];
      branch_on_transfer_high:     taken = flags_r[FLAG_T];
      branch_on_transfer_low:      taken = !flags_r[FLAG_T];
      branch_on_overflow_low:      taken = !flags_r[FLAG_V];
      branch_when_irq_on:          taken = flags_r[FLAG_I];
      branch_when_irq_off:         taken = !flags_r[FLAG_I];
      default:                     is_branch = 1'b0;
    endcase

    // signed offset, target is pc plus one plus offset
    ofs_ext = {{(PC_W-OFS_W){instr_offset[OFS_W-1]}}, instr_offset};
  end
    
  // ----------------------------------------------------------------
  // shift unit
  // ----------------------------------------------------------------
  always_comb begin
    // shift and rotate result with carry out
    is_shift = 1'b1;
    sh_res   = DATA_ZERO;
    sh_c     = 1'b0;
    unique case (instr_op)
      shift_left_logical: begin
        sh_res = {rd_data[MSB-1:0], 1'b0};
        sh_c   = rd_data[MSB];
      end
      shift_right_logical: begin
        sh_res = {1'b0, rd_data[MSB:1]};
        sh_c   = rd_data[0];
      end
      rotate_left_via_carry: begin
        sh_res = {rd_data[MSB-1:0], flags_r[FLAG_C]};
        sh_c   = rd_data[MSB];
      end
      rotate_right_via_carry: begin
        sh_res = {flags_r[FLAG_C], rd_data[MSB:1]};
        sh_c   = rd_data[0];
      end
      arith_shift_right: begin
        sh_res = {rd_data[MSB], rd_data[MSB:1]};
        sh_c   = rd_data[0];
      end
      default: is_shift = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // control and write ports
  // ----------------------------------------------------------------
  always_comb begin

    state_nxt     = state_r;
    ready_nxt     = ready_r;
    done_nxt      = 1'b0;
    pc_load_nxt   = 1'b0;
    pc_target_nxt = pc_target_r;
    reg_we_nxt    = 1'b0;
    reg_waddr_nxt = reg_waddr_r;
    reg_wdata_nxt = reg_wdata_r;
    io_re_nxt     = 1'b0;
    io_we_nxt     = 1'b0;
    io_addr_nxt   = io_addr_r;
    io_wdata_nxt  = io_wdata_r;
    io_val_nxt    = io_val_r;
    io_bit_nxt    = io_bit_r;

    unique case (state_r)
      st_idle: begin
        ready_nxt = 1'b1;
        if (accept) begin
          if (is_branch) begin
            if (taken) begin
              // two cycles: redirect now, finish next
              pc_load_nxt   = 1'b1;
              pc_target_nxt = pc_in + ofs_ext + {{(PC_W-1){1'b0}}, 1'b1};
              ready_nxt     = 1'b0;
              state_nxt     = st_branch;
            end else begin
              done_nxt = 1'b1;
            end
          end else if (is_shift) begin
            reg_we_nxt         = 1'b1;
            reg_waddr_nxt      = instr_rd_idx;
            reg_wdata_nxt      = sh_res;
            done_nxt           = 1'b1;
          end else begin
            unique case (instr_op)
              io_bit_force_one, io_bit_force_zero: begin
                // read the io register, write it back next cycle
                io_re_nxt   = 1'b1;
                io_addr_nxt = instr_io_addr;
                io_val_nxt  = (instr_op == io_bit_force_one);
                io_bit_nxt  = instr_sel;
                ready_nxt   = 1'b0;
                state_nxt   = st_io_write;
              end
              copy_bit_to_transfer_flag: begin
                done_nxt          = 1'b1;
              end
              load_bit_from_transfer_flag: begin
                reg_we_nxt                = 1'b1;
                reg_waddr_nxt             = instr_rd_idx;
                reg_wdata_nxt             = rd_data;
                reg_wdata_nxt[instr_sel]  = flags_r[FLAG_T];
                done_nxt                  = 1'b1;
              end
              flag_force_one: begin
                done_nxt             = 1'b1;
              end
              flag_force_zero: begin
                done_nxt             = 1'b1;
              end
              register_copy: begin
                reg_we_nxt    = 1'b1;
                reg_waddr_nxt = instr_rd_idx;
                reg_wdata_nxt = rr_data;
                done_nxt      = 1'b1;
              end
              default: done_nxt = 1'b1;
            endcase
          end
        end
      end
      st_branch: begin
        done_nxt  = 1'b1;
        ready_nxt = 1'b1;
        state_nxt = st_idle;
      end
      st_io_write: begin
        io_we_nxt              = 1'b1;
        io_wdata_nxt           = io_rd_data;
        io_wdata_nxt[io_bit_r] = io_val_r;
        done_nxt               = 1'b1;
        ready_nxt              = 1'b1;
        state_nxt              = st_idle;
      end
      default: begin
        ready_nxt = 1'b1;
        state_nxt = st_idle;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_r     <= st_idle;
      ready_r     <= 1'b0;
      done_r      <= 1'b0;
      pc_load_r   <= 1'b0;
      pc_target_r <= '0;
      reg_we_r    <= 1'b0;
      reg_waddr_r <= '0;
      reg_wdata_r <= DATA_ZERO;
      io_re_r     <= 1'b0;
      io_we_r     <= 1'b0;
      io_addr_r   <= '0;
      io_wdata_r  <= DATA_ZERO;
      io_val_r    <= 1'b0;
      io_bit_r    <= '0;
    end else begin
      state_r     <= state_nxt;
      ready_r     <= ready_nxt;
      done_r      <= done_nxt;
      pc_load_r   <= pc_load_nxt;
      pc_target_r <= pc_target_nxt;
      reg_we_r    <= reg_we_nxt;
      reg_waddr_r <= reg_waddr_nxt;
      reg_wdata_r <= reg_wdata_nxt;
      io_re_r     <= io_re_nxt;
      io_we_r     <= io_we_nxt;
      io_addr_r   <= io_addr_nxt;
      io_wdata_r  <= io_wdata_nxt;
      io_val_r    <= io_val_nxt;
      io_bit_r    <= io_bit_nxt;
    end
  end

  // ----------------------------------------------------------------
  // status flags
  // ----------------------------------------------------------------
  always_comb begin
    flags_nxt = flags_r;
    if (accept && is_shift) begin
      flags_nxt[FLAG_Z] = (sh_res == DATA_ZERO);
      flags_nxt[FLAG_C] = sh_c;
      flags_nxt[FLAG_N] = sh_res[MSB];
      flags_nxt[FLAG_V] = sh_res[MSB] ^ sh_c;
    end else if (accept) begin
      unique case (instr_op)
        copy_bit_to_transfer_flag: flags_nxt[FLAG_T]    = rr_data[instr_sel];
        flag_force_one:            flags_nxt[instr_sel] = 1'b1;
        flag_force_zero:           flags_nxt[instr_sel] = 1'b0;
        default:                   flags_nxt            = flags_r;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      flags_r <= FLAGS_RESET;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign instr_ready       = ready_r;
  assign done              = done_r;
  assign pc_load           = pc_load_r;
  assign pc_target         = pc_target_r;
  assign reg_we            = reg_we_r;
  assign reg_waddr         = reg_waddr_r;
  assign reg_wdata         = reg_wdata_r;
  assign io_re             = io_re_r;
  assign io_we             = io_we_r;
  assign io_addr           = io_addr_r;
  assign io_wdata          = io_wdata_r;
  assign status_flags_word = flags_r;
endmodule
`default_nettype wire

/* tb/bbfe_far_model.sv */
// Purpose: register file and io space beside the execution unit
// Assumes: reads are combinational, writes land on the clock edge
// Notes:   io read data is garbled outside the read window
`timescale 1ns/1ps
`default_nettype none
module bbfe_far_model (
  input  wire logic       ref_clk,
  input  wire logic [4:0] rd_idx,
  input  wire logic [4:0] rr_idx,
  input  wire logic       reg_we,
  input  wire logic [4:0] reg_waddr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       io_re,
  input  wire logic       io_we,
  input  wire logic [4:0] io_addr,
  input  wire logic [7:0] io_wdata,
  output logic [7:0]      rd_data,
  output logic [7:0]      rr_data,
  output logic [7:0]      io_rd_data
);
  logic [7:0] regs   [32];
  logic [7:0] io_mem [32];
  logic       win_r;
  // plain always so the bench may preload the arrays
  always @(posedge ref_clk) begin
    win_r <= io_re;
    if (reg_we) regs[reg_waddr] <= reg_wdata;
    if (io_we) io_mem[io_addr] <= io_wdata;
  end
  assign rd_data    = regs[rd_idx];
  assign rr_data    = regs[rr_idx];
  assign io_rd_data = (io_re || win_r) ? io_mem[io_addr] : ~io_mem[io_addr];
endmodule
`default_nettype wire

/* tb/bbfe_exec_properties.sv */
// Purpose: port-level checks of the execution unit
// Assumes: single clock, synchronous active-high reset
// Notes:   bound into every instance of the unit
`timescale 1ns/1ps
`default_nettype none
module bbfe_exec_properties
  import bbfe_pkg::*;
#(
  parameter int unsigned PC_W = 16
) (
  input wire logic                        ref_clk,
  input wire logic                        rst,
  input wire logic                        instr_valid,
  input wire logic                        instr_ready,
  input wire bbfe_pkg::bbfe_op_type       instr_op,
  input wire logic [bbfe_pkg::SEL_W-1:0]  instr_sel,
  input wire logic [bbfe_pkg::OFS_W-1:0]  instr_offset,
  input wire logic [PC_W-1:0]             pc_in,
  input wire logic [bbfe_pkg::DATA_W-1:0] rr_data,
  input wire logic [bbfe_pkg::DATA_W-1:0] io_rd_data,
  input wire logic                        done,
  input wire logic                        pc_load,
  input wire logic [PC_W-1:0]             pc_target,
  input wire logic [bbfe_pkg::DATA_W-1:0] reg_wdata,
  input wire logic                        io_re,
  input wire logic                        io_we,
  input wire logic [bbfe_pkg::DATA_W-1:0] io_wdata,
  input wire logic [bbfe_pkg::DATA_W-1:0] status_flags_word
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic            acc;
  logic [PC_W-1:0] tgt;
  assign acc = instr_valid && instr_ready;
  assign tgt = pc_in + PC_W'($signed(instr_offset)) + 1'b1;
  a_accept_answers: assert property (
    acc |=> done || pc_load || io_re) else $error("accepted op gave no answer");
  a_load_then_done: assert property (
    pc_load |=> done && !pc_load) else $error("taken branch not two cycles");
  a_branch_target: assert property (
    acc ##1 pc_load |-> pc_target == $past(tgt)) else $error("branch target wrong");
  a_branch_flags: assert property (
    pc_load |-> $stable(status_flags_word) ##1 $stable(status_flags_word))
    else $error("branch changed flags");
  a_io_one_bit: assert property (
    io_re |=> io_we && done && $countones(io_wdata ^ $past(io_rd_data)) <= 1)
    else $error("io write not one bit");
  a_io_ready_low: assert property (
    io_re |-> !instr_ready) else $error("ready high during io op");
  a_flag_set_one: assert property (
    acc && instr_op == flag_force_one |=>
    status_flags_word == ($past(status_flags_word) | (8'h01 << $past(instr_sel))))
    else $error("flag set wrong");
  a_copy_no_flags: assert property (
    acc && instr_op == register_copy |=> reg_wdata == $past(rr_data) &&
    $stable(status_flags_word)) else $error("register copy wrong");
endmodule
bind bbfe_exec bbfe_exec_properties #(.PC_W(PC_W)) u_props (
  .ref_clk(ref_clk), .rst(rst), .instr_valid(instr_valid), .instr_ready(instr_ready),
  .instr_op(instr_op), .instr_sel(instr_sel), .instr_offset(instr_offset), .pc_in(pc_in),
  .rr_data(rr_data), .io_rd_data(io_rd_data), .done(done), .pc_load(pc_load),
  .pc_target(pc_target), .reg_wdata(reg_wdata), .io_re(io_re), .io_we(io_we),
  .io_wdata(io_wdata), .status_flags_word(status_flags_word));
`default_nettype wire

/* tb/testbench.sv */
// Purpose: self-checking bench of the execution unit
// Assumes: far side modelled by bbfe_far_model
// Notes:   flags are preset through the flag set and clear ops
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin fail_count++; \
  $display("wrong value %s expected %0h seen %0h", n, e, g); end end
module testbench;
  import bbfe_pkg::*;
  logic        ref_clk, rst, instr_valid, instr_ready, done, pc_load, reg_we, io_re, io_we;
  bbfe_op_type instr_op, op;
  logic [2:0]  instr_sel;
  logic [6:0]  instr_offset;
  logic [4:0]  instr_rd_idx, instr_io_addr, rr_idx, reg_waddr, io_addr;
  logic [15:0] pc_in, pc_target;
  logic [7:0]  rd_data, rr_data, io_rd_data, reg_wdata, io_wdata, status_flags_word, f, m;
  logic [8:0]  x;
  logic        ld, t;
  int          cyc, fail_count, compares;
  logic [7:0]  fl [3] = '{8'h00, 8'hFF, 8'h04};
  logic [7:0]  dv [3] = '{8'h81, 8'h00, 8'h40};
  bbfe_exec #(.PC_W(16)) u_dut (.ref_clk(ref_clk), .rst(rst), .instr_valid(instr_valid),
    .instr_op(instr_op), .instr_sel(instr_sel), .instr_offset(instr_offset),
    .instr_rd_idx(instr_rd_idx), .instr_io_addr(instr_io_addr), .pc_in(pc_in),
    .rd_data(rd_data), .rr_data(rr_data), .io_rd_data(io_rd_data), .instr_ready(instr_ready),
    .done(done), .pc_load(pc_load), .pc_target(pc_target), .reg_we(reg_we),
    .reg_waddr(reg_waddr), .reg_wdata(reg_wdata), .io_re(io_re), .io_we(io_we),
    .io_addr(io_addr), .io_wdata(io_wdata), .status_flags_word(status_flags_word));
  bbfe_far_model u_far (.ref_clk(ref_clk), .rd_idx(instr_rd_idx), .rr_idx(rr_idx),
    .reg_we(reg_we), .reg_waddr(reg_waddr), .reg_wdata(reg_wdata), .io_re(io_re),
    .io_we(io_we), .io_addr(io_addr), .io_wdata(io_wdata), .rd_data(rd_data),
    .rr_data(rr_data), .io_rd_data(io_rd_data));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic print_verdict();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // one instruction: wait ready, accept, count cycles to done
  task automatic run(input bbfe_op_type o, input logic [2:0] s, output int c, output logic l);
    int n;
    n = 0;
    @(posedge ref_clk) #1;
    while (instr_ready !== 1'b1 && n < 20) begin
      @(posedge ref_clk) #1;
      n++;
    end
    instr_op = o;
    instr_sel = s;
    instr_valid = 1'b1;
    @(posedge ref_clk) #1;
    instr_valid = 1'b0;
    c = 1;
    l = pc_load;
    while (done !== 1'b1 && c < 9) begin
      @(posedge ref_clk) #1;
      c++;
      l |= pc_load;
    end
    if (done !== 1'b1 || n >= 20) begin
      fail_count++;
      print_verdict();
    end
  endtask
  task automatic setf(input logic [7:0] v);
    int c;
    logic l;
    for (int i = 0; i < 8; i++) run(v[i] ? flag_force_one : flag_force_zero, 3'(i), c, l);
  endtask
  function automatic logic tk(bbfe_op_type o, logic [2:0] s, logic [7:0] g);
    logic [2:0] b;
    logic       v;
    case (o)
      branch_on_zero_high, branch_on_zero_low: b = FLAG_Z;
      branch_on_carry_high, branch_on_carry_low, branch_unsigned_not_below,
      branch_unsigned_below: b = FLAG_C;
      branch_on_negative, branch_on_nonnegative: b = FLAG_N;
      branch_on_half_carry_high, branch_on_half_carry_low: b = FLAG_H;
      branch_on_transfer_high, branch_on_transfer_low: b = FLAG_T;
      branch_on_overflow_low: b = FLAG_V;
      branch_when_irq_on, branch_when_irq_off: b = FLAG_I;
      default: b = s;
    endcase
    v = g[b];
    if (o inside {branch_signed_not_less, branch_signed_less}) v = g[FLAG_N] ^ g[FLAG_V];
    if (o inside {branch_on_indexed_flag_high, branch_on_zero_high, branch_on_carry_high,
        branch_unsigned_below, branch_on_negative, branch_signed_less,
        branch_on_half_carry_high, branch_on_transfer_high, branch_when_irq_on}) return v;
    return ~v;
  endfunction
  function automatic logic [8:0] shf(bbfe_op_type o, logic [7:0] d, logic c);
    case (o)
      shift_left_logical: return {d, 1'b0};
      shift_right_logical: return {d[0], 1'b0, d[7:1]};
      rotate_left_via_carry: return {d, c};
      rotate_right_via_carry: return {d[0], c, d[7:1]};
      default: return {d[0], d[7], d[7:1]};
    endcase
  endfunction
  initial begin
    rst = 1'b1;
    instr_valid = 1'b0;
    instr_op = op_none;
    instr_sel = 3'h0;
    instr_offset = 7'h00;
    instr_rd_idx = 5'h03;
    instr_io_addr = 5'h09;
    rr_idx = 5'h04;
    pc_in = 16'h1000;
    repeat (6) @(posedge ref_clk);
    #1 rst = 1'b0;
    `CHK("flags", FLAGS_RESET, status_flags_word)
    `CHK("ready", 1'b0, instr_ready)
    for (int i = 0; i < 8; i++) begin
      run(flag_force_one, 3'(i), cyc, ld);
      `CHK("set", 8'h01 << i, status_flags_word)
      `CHK("fcycles", 1, cyc)
      run(flag_force_zero, 3'(i), cyc, ld);
      `CHK("clear", 8'h00, status_flags_word)
    end
    foreach (fl[k]) begin
      setf(fl[k]);
      for (int o = 0; o < 19; o++) begin
        for (int s = 0; s < ((o < 2) ? 8 : 1); s++) begin
          op = bbfe_op_type'(5'(o));
          instr_offset = o[0] ? 7'h40 : 7'h3F;
          run(op, 3'(s), cyc, ld);
          t = tk(op, 3'(s), fl[k]);
          `CHK("cycles", t ? 2 : 1, cyc)
          `CHK("load", t, ld)
          if (t) `CHK("target", pc_in + 16'($signed(instr_offset)) + 16'h0001, pc_target)
          `CHK("bflags", fl[k], status_flags_word)
          `CHK("bwe", 1'b0, reg_we)
        end
      end
    end
    foreach (dv[k]) begin
      for (int c = 0; c < 2; c++) begin
        for (int o = 21; o < 26; o++) begin
          op = bbfe_op_type'(5'(o));
          f = 8'hF0 | 8'(c);
          setf(f);
          u_far.regs[3] = dv[k];
          run(op, 3'h0, cyc, ld);
          x = shf(op, dv[k], c[0]);
          `CHK("shift", x[7:0], reg_wdata)
          `CHK("sflags", {f[7:4], x[7] ^ x[8], x[7], x[7:0] == 8'h00, x[8]}, status_flags_word)
          `CHK("scycles", 1, cyc)
          `CHK("swe", 1'b1, reg_we)
          `CHK("swaddr", 5'h03, reg_waddr)
        end
      end
    end
    setf(8'h00);
    u_far.regs[4] = 8'h20;
    run(copy_bit_to_transfer_flag, 3'h5, cyc, ld);
    `CHK("tset", 8'h40, status_flags_word)
    run(copy_bit_to_transfer_flag, 3'h4, cyc, ld);
    `CHK("tclr", 8'h00, status_flags_word)
    setf(8'h40);
    u_far.regs[3] = 8'h00;
    run(load_bit_from_transfer_flag, 3'h7, cyc, ld);
    `CHK("bitload", 8'h80, reg_wdata)
    `CHK("lflags", 8'h40, status_flags_word)
    `CHK("lcycles", 1, cyc)
    u_far.regs[4] = 8'hA5;
    run(register_copy, 3'h0, cyc, ld);
    `CHK("copy", 8'hA5, reg_wdata)
    `CHK("dest", 5'h03, reg_waddr)
    `CHK("ccycles", 1, cyc)
    `CHK("cflags", 8'h40, status_flags_word)
    m = 8'h5A;
    u_far.io_mem[9] = m;
    for (int i = 0; i < 8; i++) begin
      run(i[0] ? io_bit_force_zero : io_bit_force_one, 3'(i), cyc, ld);
      m = i[0] ? (m & ~(8'h01 << i)) : (m | (8'h01 << i));
      `CHK("iodata", m, io_wdata)
      `CHK("iocycles", 2, cyc)
      `CHK("ioflags", 8'h40, status_flags_word)
      `CHK("ioaddr", 5'h09, io_addr)
      `CHK("iowe", 1'b1, io_we)
    end
    print_verdict();
  end
endmodule
`default_nettype wire
